// file: core/reset_source_sequencer.sv
`timescale 1ns/1ps
module rss_reset_source_sequencer #(
    parameter int POWER_UP_DELAY_TIMER_CYC_1 = rss_pkg::POWER_UP_DELAY_TIMER_US_1 * rss_pkg::CLK_MHZ,
    parameter int POWER_UP_DELAY_TIMER_CYC_2 = rss_pkg::POWER_UP_DELAY_TIMER_US_2 * rss_pkg::CLK_MHZ,
    parameter int POWER_UP_DELAY_TIMER_CYC_3 = rss_pkg::POWER_UP_DELAY_TIMER_US_3 * rss_pkg::CLK_MHZ,
    parameter int FILTER_CYC = rss_pkg::FILTER_CYC
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire rss_pkg::rss_src_t src,
    input  wire logic             extResetPinIn,
    output logic                  extResetPinOut,
    output logic                  extResetPinOe,
    output logic                  pinPullUp,
    output logic                  coreReset,
    output logic                  irq,
    input  wire logic [11:0]      paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr
);

    // filter counter is eight bits wide, timer loads must be nonzero
    if (POWER_UP_DELAY_TIMER_CYC_1 < 1 || POWER_UP_DELAY_TIMER_CYC_2 < 1 || POWER_UP_DELAY_TIMER_CYC_3 < 1 || FILTER_CYC < 1 || FILTER_CYC > 255) begin : g_bad_timing
        $error("bad timing parameter");
    end

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers: async inputs pass three flops, second and third agree
    logic [2:0] pinSync;
    logic [2:0] lpSync;
    logic [2:0] nbSync;
    logic [2:0] porSync;
    logic [2:0] progSync;
    logic       pinLevel;
    logic       lpLevel;
    logic       nbLevel;
    logic       porLevel;
    logic       progLevel;

    always_ff @(posedge ref_clk) begin
        pinSync  <= {pinSync[1:0], extResetPinIn};
        lpSync   <= {lpSync[1:0], src.lowPowerDrop};
        nbSync   <= {nbSync[1:0], src.normalDrop};
        porSync  <= {porSync[1:0], src.powerOn};
        progSync <= {progSync[1:0], src.progMode};
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pinLevel  <= 1'b1;
            lpLevel   <= 1'b0;
            nbLevel   <= 1'b0;
            porLevel  <= 1'b1;
            progLevel <= 1'b0;
        end else begin
            if (pinSync[1] == pinSync[2]) pinLevel <= pinSync[2];
            if (lpSync[1] == lpSync[2]) lpLevel <= lpSync[2];
            if (nbSync[1] == nbSync[2]) nbLevel <= nbSync[2];
            if (porSync[1] == porSync[2]) porLevel <= porSync[2];
            if (progSync[1] == progSync[2]) progLevel <= progSync[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration and source qualification
    logic [6:0] cfgWord;
    logic       pinEnable;
    logic       supplyDrop;
    logic       pinLowFiltered;
    logic       progExit;
    logic       progPrev;
    logic       stackFault;
    logic       wdtFault;
    logic       instant;

    assign pinEnable = cfgWord[rss_pkg::C_LVP] | cfgWord[rss_pkg::C_PIN_EN];
    assign supplyDrop = (lpLevel & cfgWord[rss_pkg::C_LPM_EN]) | nbLevel;
    assign stackFault = cfgWord[rss_pkg::C_STK_EN] & (src.stackOverflow | src.stackUnderflow);
    assign wdtFault   = src.wdtTimeout | src.wdtWindow;
    assign progExit   = progPrev & ~progLevel;

    assign pinPullUp      = pinEnable ? 1'b1 : cfgWord[rss_pkg::C_PULL_SW];
    assign extResetPinOut = 1'b0;
    assign extResetPinOe  = 1'b0;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) progPrev <= 1'b0;
        else        progPrev <= progLevel;
    end

    // noise filter on the pin path
    logic [7:0] filtCnt;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            filtCnt        <= 8'h00;
            pinLowFiltered <= 1'b0;
        end else if (pinLevel || !pinEnable) begin
            filtCnt        <= 8'h00;
            pinLowFiltered <= 1'b0;
        end else if (filtCnt >= 8'(FILTER_CYC - 1)) begin
            pinLowFiltered <= 1'b1;
        end else begin
            filtCnt <= filtCnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-up timer
    logic [31:0] pwrtCnt;
    logic        pwrtArmed;
    logic        pwrtRun;
    logic [31:0] pwrtLoad;

    always_comb begin
        unique case (cfgWord[rss_pkg::C_POWER_UP_DELAY_TIMER_LO +: 2])
            2'b01:   pwrtLoad = 32'(POWER_UP_DELAY_TIMER_CYC_1);
            2'b10:   pwrtLoad = 32'(POWER_UP_DELAY_TIMER_CYC_2);
            2'b11:   pwrtLoad = 32'(POWER_UP_DELAY_TIMER_CYC_3);
            default: pwrtLoad = 32'h0000_0000;
        endcase
    end

    assign pwrtRun = pwrtCnt != 32'h0000_0000;

    // armed by power-on, drop or program exit, runs after release
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pwrtArmed <= 1'b1;
            pwrtCnt   <= 32'h0000_0000;
        end else if (porLevel || supplyDrop || progLevel || progExit) begin
            pwrtArmed <= 1'b1;
            pwrtCnt   <= 32'h0000_0000;
        end else if (pwrtArmed) begin
            pwrtArmed <= 1'b0;
            pwrtCnt   <= pwrtLoad;
        end else if (pwrtRun) begin
            pwrtCnt <= pwrtCnt - 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core reset
    // any source or timer holds reset
    assign instant = porLevel | supplyDrop | progLevel | pinLowFiltered | wdtFault | src.resetInstr | stackFault;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) coreReset <= 1'b1;
        else        coreReset <= instant | pwrtArmed | pwrtRun;
    end

    ////////////////////////////////////////////////////////////////////////////
    // cause flags
    logic [rss_pkg::CAUSE_W-1:0] cause;
    logic [1:0]                  status;
    logic [rss_pkg::EV_W-1:0]    irqStatus;
    logic [rss_pkg::EV_W-1:0]    irqMask;
    logic [rss_pkg::EV_W-1:0]    events;
    logic                        wrAcc;
    logic                        rdAcc;
    logic                        powerLike;

    assign wrAcc = psel & penable & pwrite;
    assign rdAcc = psel & penable & ~pwrite;
    assign powerLike = porLevel | progExit;

    // flags held until software rewrites or power-on/program exit reloads them; hardware set wins
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cause  <= rss_pkg::CAUSE_POR_VALUE;
            status <= 2'b11;
        end else if (powerLike) begin
            cause  <= rss_pkg::CAUSE_POR_VALUE;
            status <= 2'b11;
        end else begin
            if (wrAcc && paddr == rss_pkg::REG_CAUSE && pstrb[0])
                cause <= pwdata[rss_pkg::CAUSE_W-1:0];
            if (wrAcc && paddr == rss_pkg::REG_STATUS && pstrb[0])
                status <= pwdata[1:0];
            if (supplyDrop) cause[rss_pkg::B_DROP_N] <= 1'b0;
            if (pinLowFiltered) cause[rss_pkg::B_PIN_N] <= 1'b0;
            if (wdtFault) begin
                cause[rss_pkg::B_WDT_N]   <= 1'b0;
                cause[rss_pkg::B_WINVIOL] <= src.wdtWindow;
                status[rss_pkg::B_TO_N]   <= 1'b0;
                status[rss_pkg::B_PD_N]   <= 1'b1;
            end
            if (src.resetInstr) cause[rss_pkg::B_INSTR_N] <= 1'b0;
            if (cfgWord[rss_pkg::C_STK_EN] && src.stackOverflow) cause[rss_pkg::B_STACK_OVERFLOW_FLAG] <= 1'b1;
            if (cfgWord[rss_pkg::C_STK_EN] && src.stackUnderflow) cause[rss_pkg::B_STACK_UNDERFLOW_FLAG] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts and configuration
    // event bits placed by the shared status and mask layout
    always_comb begin
        events                   = '0;
        events[rss_pkg::E_DROP]  = supplyDrop;
        events[rss_pkg::E_PIN]   = pinLowFiltered;
        events[rss_pkg::E_WDT]   = wdtFault;
        events[rss_pkg::E_INSTR] = src.resetInstr;
        events[rss_pkg::E_STACK] = stackFault;
        events[rss_pkg::E_PROG]  = progExit;
    end
    assign irq    = |(irqStatus & irqMask);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) irqStatus <= '0;
        else if (wrAcc && paddr == rss_pkg::REG_IRQ_ST && pstrb[0])
            irqStatus <= (irqStatus & ~pwdata[rss_pkg::EV_W-1:0]) | events;
        else
            irqStatus <= irqStatus | events;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) irqMask <= '0;
        else if (wrAcc && paddr == rss_pkg::REG_IRQ_MSK && pstrb[0])
            irqMask <= pwdata[rss_pkg::EV_W-1:0];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) cfgWord <= rss_pkg::CONFIG_ERASED;
        else if (wrAcc && paddr == rss_pkg::REG_CONFIG && pstrb[0])
            cfgWord <= pwdata[6:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb read path, zero wait
    logic mapped;
    assign mapped  = paddr == rss_pkg::REG_CAUSE || paddr == rss_pkg::REG_STATUS ||
                     paddr == rss_pkg::REG_IRQ_ST || paddr == rss_pkg::REG_IRQ_MSK ||
                     paddr == rss_pkg::REG_CONFIG;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                rss_pkg::REG_CAUSE:   prdata <= 32'(cause);
                rss_pkg::REG_STATUS:  prdata <= 32'(status);
                rss_pkg::REG_IRQ_ST:  prdata <= 32'(irqStatus);
                rss_pkg::REG_IRQ_MSK: prdata <= 32'(irqMask);
                rss_pkg::REG_CONFIG:  prdata <= 32'(cfgWord);
                default:              prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// file: core/rss_pkg.sv
package rss_pkg;

    localparam logic [11:0] REG_CAUSE   = 12'h000;
    localparam logic [11:0] REG_STATUS  = 12'h004;
    localparam logic [11:0] REG_IRQ_ST  = 12'h008;
    localparam logic [11:0] REG_IRQ_MSK = 12'h00C;
    localparam logic [11:0] REG_CONFIG  = 12'h010;

    // cause register bit positions
    localparam int B_WINVIOL = 0;
    localparam int B_WDT_N   = 1;
    localparam int B_INSTR_N = 2;
    localparam int B_PIN_N   = 3;
    localparam int B_POR_N   = 4;
    localparam int B_DROP_N  = 5;
    localparam int B_STACK_UNDERFLOW_FLAG  = 6;
    localparam int B_STACK_OVERFLOW_FLAG  = 7;
    localparam int CAUSE_W   = 8;
    // status register bits
    localparam int B_PD_N    = 0;
    localparam int B_TO_N    = 1;

    localparam logic [7:0] CAUSE_POR_VALUE = 8'h0E;
    localparam logic [7:0] CAUSE_RST_VALUE = 8'h3E;

    // event bits, same layout for status and mask
    localparam int EV_W      = 6;
    localparam int E_DROP    = 0;
    localparam int E_PIN     = 1;
    localparam int E_WDT     = 2;
    localparam int E_INSTR   = 3;
    localparam int E_STACK   = 4;
    localparam int E_PROG    = 5;

    // config register layout
    localparam int C_POWER_UP_DELAY_TIMER_LO   = 0;
    localparam int C_LPM_EN    = 2;
    localparam int C_PIN_EN    = 3;
    localparam int C_LVP       = 4;
    localparam int C_STK_EN    = 5;
    localparam int C_PULL_SW   = 6;
    localparam logic [6:0] CONFIG_ERASED = 7'h00;

    // power-up delay choices in microseconds
    localparam int CLK_MHZ     = 125;
    localparam int POWER_UP_DELAY_TIMER_US_1   = 1000;
    localparam int POWER_UP_DELAY_TIMER_US_2   = 4000;
    localparam int POWER_UP_DELAY_TIMER_US_3   = 16000;
    localparam int FILTER_NS   = 200;
    localparam int FILTER_CYC  = (FILTER_NS * CLK_MHZ) / 1000;

    typedef struct packed {
        logic lowPowerDrop;
        logic normalDrop;
        logic powerOn;
        logic progMode;
        logic wdtTimeout;
        logic wdtWindow;
        logic resetInstr;
        logic stackOverflow;
        logic stackUnderflow;
    } rss_src_t;

endpackage

// file: testbench/rss_pin_driver.sv
`timescale 1ns/1ps
module rss_pin_driver (
    input  wire logic ref_clk,
    input  wire logic holdLow,
    input  wire logic pullUp,
    input  wire logic devOut,
    input  wire logic devOe,
    output logic      pinLevel
);
    logic lastLevel = 1'b1;
    always_comb begin
        if (devOe) begin
            pinLevel = devOut;
        end else if (holdLow) begin
            pinLevel = 1'b0;
        end else if (pullUp) begin
            pinLevel = 1'b1;
        end else begin
            pinLevel = ~lastLevel;
        end
    end
    always @(posedge ref_clk) lastLevel <= pinLevel;
endmodule

// file: testbench/rss_props.sv
`timescale 1ns/1ps
module rss_props #(
    parameter int FILTER_CYC = 25
) (
    input wire logic              ref_clk,
    input wire logic              rst_b,
    input wire rss_pkg::rss_src_t src,
    input wire logic              extResetPinIn,
    input wire logic              extResetPinOe,
    input wire logic              pinPullUp,
    input wire logic              coreReset,
    input wire logic [11:0]       paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata
);
    logic [6:0] cfg;
    logic [7:0] lowCnt;
    logic       pinEn;
    assign pinEn = cfg[3] | cfg[4];
    // shadow of the config register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cfg <= 7'h00;
        end else if (psel && penable && pwrite && paddr == rss_pkg::REG_CONFIG) begin
            cfg <= pwdata[6:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !pinEn || extResetPinIn) begin
            lowCnt <= 8'h00;
        end else if (lowCnt != 8'hFF) begin
            lowCnt <= lowCnt + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_pull_up: assert property (pinPullUp == (pinEn | cfg[6]))
        else $error("pull-up level wrong");
    a_pin_input: assert property (!extResetPinOe)
        else $error("reset pin driven");
    a_low_power: assert property ((src.lowPowerDrop && cfg[2]) [*8] |-> coreReset)
        else $error("low-power drop ignored");
    a_supply_drop: assert property (src.normalDrop [*8] |-> coreReset)
        else $error("supply drop ignored");
    a_pin_hold: assert property (lowCnt >= FILTER_CYC + 8 |-> coreReset)
        else $error("pin low ignored");
    a_instr_reset: assert property (src.resetInstr |-> ##[1:3] coreReset)
        else $error("instruction reset missing");
    a_wdt_reset: assert property (src.wdtTimeout || src.wdtWindow |-> ##[1:3] coreReset)
        else $error("watchdog reset missing");
    a_stack_reset: assert property ((src.stackOverflow || src.stackUnderflow) && cfg[5] |-> ##[1:3] coreReset)
        else $error("stack reset missing");
    a_timer_hold: assert property (($fell(src.powerOn) || $fell(src.normalDrop)) && cfg[1:0] != 2'h0 |-> coreReset [*8])
        else $error("timer too short");
    a_release_late: assert property ($fell(coreReset) |-> !$past(src.powerOn, 3) && !$past(src.normalDrop, 3))
        else $error("early release");
    cover property ($fell(coreReset));
    cover property (src.wdtWindow ##1 coreReset);
    cover property (lowCnt == 8'h0A ##1 extResetPinIn);
endmodule
bind rss_reset_source_sequencer rss_props #(.FILTER_CYC(FILTER_CYC)) u_props (.ref_clk(ref_clk), .rst_b(rst_b),
    .src(src), .extResetPinIn(extResetPinIn), .extResetPinOe(extResetPinOe), .pinPullUp(pinPullUp),
    .coreReset(coreReset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));

// file: testbench/reset_source_sequencer_test.sv
`timescale 1ns/1ps
module reset_source_sequencer_test;
    localparam logic [8:0] SRC_T [13] = '{9'h010, 9'h008, 9'h004, 9'h002, 9'h001, 9'h002, 9'h000, 9'h000, 9'h000,
        9'h000, 9'h100, 9'h100, 9'h020};
    localparam logic [6:0] CFG_T [13] = '{7'h00, 7'h00, 7'h00, 7'h20, 7'h20, 7'h00, 7'h10, 7'h08, 7'h40, 7'h08,
        7'h00, 7'h04, 7'h00};
    localparam int LEN_T [13] = '{1, 1, 1, 1, 1, 1, 40, 40, 40, 10, 10, 10, 10};
    localparam logic [7:0] CAUSE_T [13] = '{8'h3C, 8'h3D, 8'h3A, 8'hBE, 8'h7E, 8'h3E, 8'h36, 8'h36, 8'h3E, 8'h3E,
        8'h3E, 8'h1E, 8'h0E};
    localparam logic [5:0] EV_T [13] = '{6'h04, 6'h04, 6'h08, 6'h10, 6'h10, 6'h00, 6'h02, 6'h02, 6'h00, 6'h00,
        6'h00, 6'h01, 6'h20};
    localparam int PW_T [4] = '{0, 10, 20, 40};
    logic              ref_clk, rst_b, holdLow, sawRst, pinLevel, pinOut, pinOe, pinPullUp, coreReset, irq;
    logic              psel, penable, pwrite, pready, pslverr, er;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [3:0]        pstrb = 4'hF;
    rss_pkg::rss_src_t src;
    int                nFail = 0, testsRun = 0, n;

    rss_reset_source_sequencer #(.POWER_UP_DELAY_TIMER_CYC_1(10), .POWER_UP_DELAY_TIMER_CYC_2(20), .POWER_UP_DELAY_TIMER_CYC_3(40), .FILTER_CYC(25)) u_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .src(src), .extResetPinIn(pinLevel), .extResetPinOut(pinOut),
        .extResetPinOe(pinOe), .pinPullUp(pinPullUp), .coreReset(coreReset), .irq(irq), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    rss_pin_driver u_far (.ref_clk(ref_clk), .holdLow(holdLow), .pullUp(pinPullUp), .devOut(pinOut),
        .devOe(pinOe), .pinLevel(pinLevel));

    initial begin
        ref_clk = 0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (coreReset === 1'b1) sawRst <= 1'b1;
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            nFail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finishTest;
        $display("checks %0d fails %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, wd};
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic waitRel;
        n = 0;
        while (coreReset !== 1'b0 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 300) begin
            nFail++;
            $display("MISMATCH t=%0t core reset never released", $time);
        end
    endtask
    task automatic run(input int k);
        apb(1, rss_pkg::REG_CONFIG, CFG_T[k]);
        apb(1, rss_pkg::REG_CAUSE, 32'h3E);
        chk(pinPullUp, |CFG_T[k][4:3] | CFG_T[k][6]);
        apb(1, rss_pkg::REG_IRQ_ST, 32'h3F);
        sawRst = 0;
        src <= SRC_T[k];
        holdLow <= (SRC_T[k] == 0);
        repeat (LEN_T[k]) @(posedge ref_clk);
        src <= 9'h000;
        holdLow <= 0;
        repeat (12) @(posedge ref_clk);
        waitRel;
        chk(sawRst, EV_T[k] != 0);
        apb(0, rss_pkg::REG_CAUSE, 0);
        chk(rd, CAUSE_T[k]);
        apb(0, rss_pkg::REG_IRQ_ST, 0);
        chk(rd, EV_T[k]);
        chk(irq, EV_T[k] != 0);
        apb(1, rss_pkg::REG_IRQ_ST, 32'h3F);
        @(posedge ref_clk);
        chk(irq, 0);
        if (k < 2) begin
            apb(0, rss_pkg::REG_STATUS, 0);
            chk(rd[1:0], 2'b01);
        end
    endtask
    initial begin
        {rst_b, holdLow, sawRst, psel, penable, pwrite, paddr, pwdata} = '0;
        src = 9'h040;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1;
        apb(0, rss_pkg::REG_CAUSE, 0);
        chk(rd, 32'h0E);
        apb(0, rss_pkg::REG_STATUS, 0);
        chk(rd, 32'h03);
        apb(0, rss_pkg::REG_CONFIG, 0);
        chk(rd, 32'h00);
        apb(0, 12'h014, 0);
        chk({rd[30:0], er}, 32'h01);
        apb(1, rss_pkg::REG_IRQ_MSK, 32'h3F);
        for (int s = 0; s < 4; s++) begin
            apb(1, rss_pkg::REG_CONFIG, s);
            src <= 9'h080;
            repeat (10) @(posedge ref_clk);
            src <= 9'h000;
            waitRel;
            chk(n >= PW_T[s] + 3 && n <= PW_T[s] + 12, 1);
            apb(0, rss_pkg::REG_CAUSE, 0);
            chk(rd[5], 0);
        end
        for (int k = 0; k < 13; k++) run(k);
        finishTest;
    end
    initial begin
        #160000;
        nFail++;
        finishTest;
    end
endmodule
